// ---- hdl/ssp_pkg.sv ----
`default_nettype none
package ssp_pkg;
	// ==========================================================
	// serial word layout
	localparam int WORD_W = 24;
	localparam int SEL_W = 2;
	localparam int SEL_LSB = 0;
	localparam logic [1:0] SEL_REF = 2'h0;
	localparam logic [1:0] SEL_FB = 2'h1;
	localparam logic [1:0] SEL_FUNC = 2'h2;
	localparam logic [1:0] SEL_INIT = 2'h3;
	// function / initialization word fields
	localparam int BIT_HOLD = 2;
	localparam int BIT_PD1 = 3;
	localparam int BIT_PD2 = 21;
	localparam int MON_LSB = 4;
	localparam int MON_W = 3;
	// reference word fields
	localparam int BIT_SYNC = 21;
	localparam int BIT_DLY = 22;
	// monitor select codes
	localparam logic [2:0] MON_LOW = 3'h0;
	localparam logic [2:0] MON_LOCK = 3'h1;
	localparam logic [2:0] MON_FB = 3'h2;
	localparam logic [2:0] MON_HIGH = 3'h3;
	localparam logic [2:0] MON_REF = 3'h4;
	// ==========================================================
	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_FUNC = 8'h04;
	localparam logic [7:0] ADDR_REF = 8'h08;
	localparam logic [7:0] ADDR_FB = 8'h0C;
	localparam logic [7:0] ADDR_LOAD = 8'h10;
	localparam logic [23:0] LATCH_RESET = 24'h000000;
	// status bits
	localparam int ST_CE = 0;
	localparam int ST_PD = 1;
	localparam int ST_HOLD = 2;
	localparam int ST_SOFT_PD = 3;
	localparam int ST_ARMED = 4;
	localparam int ST_SETTLED = 5;
	localparam int ST_LOCK = 6;
	localparam int ST_W = 7;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 8;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage
`default_nettype wire

// ---- hdl/ssp_shifter.sv ----
`timescale 1ns/100ps
`default_nettype none
// shifts serial data in on each rising link clock edge
module ssp_shifter
(
	input wire logic sclk,
	input wire logic hresetn,
	input wire logic sdata,
	output logic [ssp_pkg::WORD_W-1:0] word
);
	import ssp_pkg::*;

	logic [WORD_W-1:0] next_word;

	// ==========================================================
	// input register
	always_comb
	begin
		next_word = {word[WORD_W-2:0], sdata};
	end

	always_ff @(posedge sclk or negedge hresetn)
	begin
		if (!hresetn)
			word <= LATCH_RESET;
		else
			word <= next_word;
	end
endmodule
`default_nettype wire

// ---- hdl/ssp_top.sv ----
// Contract
// - an init word load also loads the function settings.
// - init load fires reset pulse holding counters and three-stating charge pump.
// - first feedback load after init fires the pulse; later ones do not.
// - enable pin low forces power-down at once, with no clock.
// - enable high leaves power-down and restarts counters aligned.
// - latch contents survive enable power-down cycles.
// - hold bit keeps counters at load, pump off, no synchronous power-down.
// - reference bit 21 set retimes prescaler to RF input.
// - reference bit 22 set retimes to delayed RF input.
// - monitor pin select field can present lock indication.
// - hold flag is function bit 2; when set counters held.
// - select 10 is function write; 11 same plus init pulse.
// - 24 bits shift on rising serial clock; strobe rise loads latch.
`timescale 1ns/100ps
`default_nettype none
module ssp_top
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic latch_strobe,
	input wire logic chip_enable,
	input wire logic lock_indicator,
	input wire logic ref_div_out,
	input wire logic fb_div_out,
	input wire logic cp_event,
	output logic power_down,
	output logic counter_hold,
	output logic charge_pump_tristate,
	output logic reset_pulse,
	output logic counter_restart,
	output logic prescaler_retime,
	output logic retime_delay_select,
	output logic monitor_out,
	output logic bias_settled,
	output logic [ssp_pkg::WORD_W-1:0] func_latch,
	output logic [ssp_pkg::WORD_W-1:0] ref_latch,
	output logic [ssp_pkg::WORD_W-1:0] fb_latch
);
	import ssp_pkg::*;

	// ==========================================================
	// serial input register on the link clock
	logic [WORD_W-1:0] shift_word;

	ssp_shifter u_shifter
	(
		.sclk(sclk),
		.hresetn(hresetn),
		.sdata(sdata),
		.word(shift_word)
	);

	// ==========================================================
	// pin synchronisers: bit 0 strobe, bit 1 enable
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] pin_state;
	logic [1:0] next_pin_state;
	logic strobe_rise;
	logic ce_high;

	always_comb
	begin
		next_pin_state = pin_state;
		for (int i = 0; i < 2; i++)
		begin
			if (sync2[i] == sync3[i])
				next_pin_state[i] = sync3[i];
		end
		strobe_rise = next_pin_state[0] & ~pin_state[0];
		ce_high = pin_state[1];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
			sync3 <= 2'h0;
			pin_state <= 2'h0;
		end
		else
		begin
			sync1 <= {chip_enable, latch_strobe};
			sync2 <= sync1;
			sync3 <= sync2;
			pin_state <= next_pin_state;
		end
	end

	// ==========================================================
	// bus slave
	logic wr_pend;
	logic [ADDR_W-1:0] wr_addr;
	logic next_wr_pend;
	logic [ADDR_W-1:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic addr_phase;
	logic [ST_W-1:0] status;
	logic soft_pd;
	logic armed;

	always_comb
	begin
		addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);
		status = '0;
		status[ST_CE] = ce_high;
		status[ST_PD] = power_down;
		status[ST_HOLD] = counter_hold;
		status[ST_SOFT_PD] = soft_pd;
		status[ST_ARMED] = armed;
		status[ST_SETTLED] = bias_settled;
		status[ST_LOCK] = lock_indicator;
		next_wr_pend = addr_phase & hwrite;
		next_wr_addr = addr_phase ? haddr[ADDR_W-1:0] : wr_addr;
		next_hrdata = hrdata;
		if (addr_phase & ~hwrite)
		begin
			case (haddr[ADDR_W-1:0])
				ADDR_STATUS: next_hrdata = {{(32-ST_W){1'b0}}, status};
				ADDR_FUNC: next_hrdata = {8'h00, func_latch};
				ADDR_REF: next_hrdata = {8'h00, ref_latch};
				ADDR_FB: next_hrdata = {8'h00, fb_latch};
				default: next_hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= ADDR_STATUS;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY[0];
		end
	end

	// ==========================================================
	// latch loading: serial strobe first, bus load word otherwise
	logic load;
	logic [WORD_W-1:0] load_word;
	logic [SEL_W-1:0] load_sel;

	always_comb
	begin
		load = 1'b0;
		load_word = shift_word;
		if (strobe_rise)
			load = 1'b1;
		else if (wr_pend && (wr_addr == ADDR_LOAD))
		begin
			load = 1'b1;
			load_word = hwdata[WORD_W-1:0];
		end
		load_sel = load_word[SEL_LSB +: SEL_W];
	end

	logic [WORD_W-1:0] next_func_latch;
	logic [WORD_W-1:0] next_ref_latch;
	logic [WORD_W-1:0] next_fb_latch;
	logic next_armed;
	logic next_reset_pulse;

	always_comb
	begin
		next_func_latch = func_latch;
		next_ref_latch = ref_latch;
		next_fb_latch = fb_latch;
		next_armed = armed;
		next_reset_pulse = 1'b0;
		if (load)
		begin
			case (load_sel)
				SEL_REF: next_ref_latch = load_word;
				SEL_FB:
				begin
					next_fb_latch = load_word;
					next_reset_pulse = armed;
					next_armed = 1'b0;
				end
				SEL_FUNC: next_func_latch = load_word;
				SEL_INIT:
				begin
					next_func_latch = load_word;
					next_reset_pulse = 1'b1;
					next_armed = 1'b1;
				end
				default: next_func_latch = func_latch;
			endcase
		end
	end

	// latches are cleared only by hresetn, never by the enable pin
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			func_latch <= LATCH_RESET;
			ref_latch <= LATCH_RESET;
			fb_latch <= LATCH_RESET;
			armed <= 1'b0;
			reset_pulse <= 1'b0;
		end
		else
		begin
			func_latch <= next_func_latch;
			ref_latch <= next_ref_latch;
			fb_latch <= next_fb_latch;
			armed <= next_armed;
			reset_pulse <= next_reset_pulse;
		end
	end

	// ==========================================================
	// power-down, counter hold and aligned restart
	logic next_soft_pd;
	logic next_power_down;
	logic hold_flag;
	logic next_counter_hold;
	logic next_counter_restart;

	always_comb
	begin
		hold_flag = next_func_latch[BIT_HOLD];
		// synchronous mode waits for a pump event; hold never starts it
		next_soft_pd = func_latch[BIT_PD1]
			& (soft_pd | ~func_latch[BIT_PD2] | cp_event);
		next_power_down = ~ce_high | next_soft_pd;
		next_counter_hold = next_power_down | hold_flag
			| next_reset_pulse;
		// both dividers leave load state on the same edge
		next_counter_restart = counter_hold & ~next_counter_hold;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			soft_pd <= 1'b0;
			counter_hold <= 1'b1;
			charge_pump_tristate <= 1'b1;
			counter_restart <= 1'b0;
		end
		else
		begin
			soft_pd <= next_soft_pd;
			counter_hold <= next_counter_hold;
			charge_pump_tristate <= next_counter_hold;
			counter_restart <= next_counter_restart;
		end
	end

	// enable low sets power-down asynchronously
	always_ff @(posedge hclk or negedge hresetn or negedge chip_enable)
	begin
		if (!hresetn)
			power_down <= 1'b1;
		else if (!chip_enable)
			power_down <= 1'b1;
		else
			power_down <= next_power_down;
	end

	// ==========================================================
	// bias settle timer after enable rises
	logic [SETTLE_W-1:0] settle_cnt;
	logic [SETTLE_W-1:0] next_settle_cnt;
	logic next_bias_settled;

	always_comb
	begin
		next_settle_cnt = settle_cnt;
		if (!ce_high)
			next_settle_cnt = SETTLE_CYC[SETTLE_W-1:0];
		else if (settle_cnt != '0)
			next_settle_cnt = settle_cnt - 1'b1;
		next_bias_settled = ce_high & (next_settle_cnt == '0);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			settle_cnt <= SETTLE_CYC[SETTLE_W-1:0];
			bias_settled <= 1'b0;
		end
		else
		begin
			settle_cnt <= next_settle_cnt;
			bias_settled <= next_bias_settled;
		end
	end

	// ==========================================================
	// prescaler retiming and monitor pin
	logic next_prescaler_retime;
	logic next_retime_delay_select;
	logic next_monitor_out;
	logic [MON_W-1:0] mon_sel;

	always_comb
	begin
		next_prescaler_retime = next_ref_latch[BIT_SYNC];
		next_retime_delay_select = next_ref_latch[BIT_DLY];
		mon_sel = func_latch[MON_LSB +: MON_W];
		case (mon_sel)
			MON_LOCK: next_monitor_out = lock_indicator;
			MON_FB: next_monitor_out = fb_div_out;
			MON_HIGH: next_monitor_out = 1'b1;
			MON_REF: next_monitor_out = ref_div_out;
			MON_LOW: next_monitor_out = 1'b0;
			default: next_monitor_out = 1'b0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prescaler_retime <= 1'b0;
			retime_delay_select <= 1'b0;
			monitor_out <= 1'b0;
		end
		else
		begin
			prescaler_retime <= next_prescaler_retime;
			retime_delay_select <= next_retime_delay_select;
			monitor_out <= next_monitor_out;
		end
	end
endmodule
`default_nettype wire

// ---- dv/ssp_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// startup checker
module ssp_props
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic chip_enable,
	input wire logic lock_indicator,
	input wire logic power_down,
	input wire logic counter_hold,
	input wire logic charge_pump_tristate,
	input wire logic reset_pulse,
	input wire logic counter_restart,
	input wire logic prescaler_retime,
	input wire logic retime_delay_select,
	input wire logic monitor_out,
	input wire logic [ssp_pkg::WORD_W-1:0] func_latch,
	input wire logic [ssp_pkg::WORD_W-1:0] ref_latch
);
	import ssp_pkg::*;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	pd_async_a: assert property (!chip_enable |-> power_down)
		else $error("pd late");
	hold_flag_a: assert property (func_latch[BIT_HOLD] |-> counter_hold)
		else $error("hold flag");
	pulse_hold_a: assert property (reset_pulse |-> counter_hold)
		else $error("pulse hold");
	pump_off_a: assert property (charge_pump_tristate == counter_hold)
		else $error("pump");
	pulse_one_a: assert property (reset_pulse |=> !reset_pulse)
		else $error("pulse len");
	restart_a: assert property ($fell(counter_hold) |-> ##[0:1] counter_restart)
		else $error("restart");
	sync_bit_a: assert property ($stable(ref_latch) |->
		prescaler_retime == ref_latch[BIT_SYNC])
		else $error("sync");
	delay_bit_a: assert property ($stable(ref_latch) |->
		retime_delay_select == ref_latch[BIT_DLY])
		else $error("dly");
	mon_lock_a: assert property (func_latch[6:4] == MON_LOCK |=>
		monitor_out == $past(lock_indicator))
		else $error("monitor");
	cover property (reset_pulse);
	cover property (counter_restart);
	cover property (monitor_out && func_latch[6:4] == MON_LOCK);
endmodule
bind ssp_top ssp_props ssp_props_i (.*);
`default_nettype wire

// ---- dv/ssp_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// host serial port model
module ssp_host
(
	output logic sclk,
	output logic sdata,
	output logic latch_strobe
);
	initial
	begin
		sclk = 0;
		sdata = 1;
		latch_strobe = 0;
	end
	task send(input logic [23:0] w);
		#13;
		for (int i = 23; i >= 0; i--)
		begin
			sdata = w[i];
			#40 sclk = 1;
			#40 sclk = 0;
		end
		#40 latch_strobe = 1;
		#700 latch_strobe = 0;
		sdata = ~sdata;
		#400;
	endtask
endmodule
`default_nettype wire

// ---- dv/ssp_top_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) \
	begin \
		cmp_count++; \
		if ((s) !== (e)) \
		begin \
			errors++; \
			$display("mismatch %s exp %0h got %0h", n, e, s); \
		end \
	end
module ssp_top_test;
	import ssp_pkg::*;
	logic hclk, hresetn, hwrite, chip_enable, lock_indicator;
	logic sclk, sdata, latch_strobe, hreadyout, power_down;
	logic counter_hold, charge_pump_tristate, reset_pulse;
	logic counter_restart, prescaler_retime, retime_delay_select;
	logic monitor_out, bias_settled, ref_div_out, fb_div_out, cp_event;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [23:0] func_latch, ref_latch, fb_latch;
	int errors = 0;
	int cmp_count = 0;
	int npulse = 0;
	int cyc = 0;
	ssp_top ssp_top_i (.hsel(1'b1), .hready(hreadyout), .hsize(3'h2),
		.hresp(), .*);
	ssp_host host_i (.sclk, .sdata, .latch_strobe);
	// ==========================================
	// clock, watchdog, pulse count
	initial
	begin
		hclk = 0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		cyc++;
		if (reset_pulse === 1'b1)
			npulse++;
		if (cyc == 5000)
		begin
			errors++;
			finish_test;
		end
	end
	task finish_test;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// ==========================================
	// scenarios
	task t_init;
		int n;
		n = npulse;
		host_i.send(24'h000013);
		`CHK("func", 22'h000004, func_latch[23:2])
		`CHK("pulse", n + 1, npulse)
		host_i.send(24'h600104);
		`CHK("ref", 22'h180041, ref_latch[23:2])
		`CHK("func", 22'h000004, func_latch[23:2])
		`CHK("sync", 1'b1, prescaler_retime)
		`CHK("dly", 1'b1, retime_delay_select)
		host_i.send(24'h012345);
		`CHK("pulse", n + 2, npulse)
		host_i.send(24'h000101);
		`CHK("pulse", n + 2, npulse)
		`CHK("hold", 1'b0, counter_hold)
	endtask
	task t_hold;
		host_i.send(24'h000006);
		`CHK("hold", 1'b1, counter_hold)
		`CHK("pd", 1'b0, power_down)
		host_i.send(24'h000100);
		host_i.send(24'h000201);
		`CHK("pump", 1'b1, charge_pump_tristate)
		host_i.send(24'h000002);
		`CHK("hold", 1'b0, counter_hold)
		`CHK("sync", 1'b0, prescaler_retime)
	endtask
	task t_ce;
		int i;
		@(posedge hclk) chip_enable <= 1'b0;
		#1;
		`CHK("pd", 1'b1, power_down)
		host_i.send(24'h000022);
		host_i.send(24'h000500);
		host_i.send(24'h000301);
		@(posedge hclk) chip_enable <= 1'b1;
		i = 0;
		while (counter_restart !== 1'b1 && i < 20)
		begin
			@(negedge hclk);
			i++;
		end
		`CHK("restart", 1'b1, counter_restart)
		`CHK("settled", 1'b0, bias_settled)
		repeat (14) @(negedge hclk);
		`CHK("settled", 1'b1, bias_settled)
		@(posedge hclk) chip_enable <= 1'b0;
		repeat (5) @(posedge hclk);
		chip_enable <= 1'b1;
		repeat (20) @(negedge hclk);
		`CHK("pd", 1'b0, power_down)
		`CHK("fb", 22'h0000C0, fb_latch[23:2])
		`CHK("func", 22'h000008, func_latch[23:2])
	endtask
	task t_bus;
		int n;
		n = npulse;
		ahb(1'b1, ADDR_LOAD, 32'h00000032);
		ahb(1'b0, ADDR_FUNC, 32'h0);
		`CHK("func", 32'h00000032, rd)
		`CHK("mon", 1'b1, monitor_out)
		ahb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		ahb(1'b1, ADDR_LOAD, 32'h00000013);
		repeat (3) @(negedge hclk);
		`CHK("pulse", n + 1, npulse)
		for (int v = 0; v < 2; v++)
		begin
			@(posedge hclk) lock_indicator <= v[0];
			repeat (3) @(negedge hclk);
			`CHK("lock", v[0], monitor_out)
		end
		ahb(1'b1, ADDR_LOAD, 32'h00000012);
		repeat (3) @(negedge hclk);
		`CHK("pulse", n + 1, npulse)
	endtask
	task t_mon;
		ahb(1'b1, ADDR_LOAD, 32'h00000022);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge hclk);
			fb_div_out <= v[0];
			ref_div_out <= ~v[0];
			repeat (3) @(negedge hclk);
			`CHK("mon fb", v[0], monitor_out)
		end
		ahb(1'b1, ADDR_LOAD, 32'h00000042);
		repeat (3) @(negedge hclk);
		`CHK("mon ref", 1'b0, monitor_out)
	endtask
	task t_sync_pd;
		ahb(1'b1, ADDR_LOAD, 32'h0020000E);
		repeat (3) @(negedge hclk);
		`CHK("pd", 1'b0, power_down)
		`CHK("hold", 1'b1, counter_hold)
		@(posedge hclk);
		cp_event <= 1'b1;
		@(posedge hclk);
		cp_event <= 1'b0;
		repeat (2) @(negedge hclk);
		`CHK("pd", 1'b1, power_down)
		ahb(1'b1, ADDR_LOAD, 32'h00000002);
		repeat (3) @(negedge hclk);
		`CHK("pd", 1'b0, power_down)
		`CHK("hold", 1'b0, counter_hold)
	endtask
	initial
	begin
		hresetn = 0;
		htrans = 2'h0;
		haddr = 0;
		hwrite = 0;
		hwdata = 0;
		chip_enable = 1;
		lock_indicator = 0;
		ref_div_out = 0;
		fb_div_out = 0;
		cp_event = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1;
		repeat (6) @(posedge hclk);
		t_init;
		t_hold;
		t_ce;
		t_bus;
		t_mon;
		t_sync_pd;
		finish_test;
	end
endmodule
`default_nettype wire
